//--- core/usc_top.sv
// serial port control and status flags with axi4-lite register access
//
// The register addresses and the AXI4-Lite register port were decided locally.
`include "usc_map.svh"
// How it works
// - parity error flag 0 clear, 1 seen, sticky
// - flag set when oldest byte parity mismatches
// - receive disabled stops loading, reads still work
// - extra bit carries extra_tx_bit without parity
// - extra_rx_bit captured only with extra bit enabled
// - extra-bit enable adds one bit per character when parity is off
// - tx done set at stop bit start
// - enabled tx done requests interrupt, software clears
// - rx ready set at stop sampling instant
// - rx ready follows receive fifo occupancy
// - rx ready cleared by hardware when empty
// - empty read returns last byte, fifo unchanged
module usc_top import usc_pkg::*; #(
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] aw_q;
  logic [7:0] w_q;
  logic [1:0] ws_q;
  logic [15:0] w16_q;
  logic aw_hold;
  logic w_hold;
  logic wr_go;
  logic rd_go;
  logic next_aw_hold;
  logic next_w_hold;
  logic next_bvalid;
  logic ren;
  logic etx;
  logic erx;
  logic pe;
  logic extra_bit_enable;
  usc_parity_t spt;
  logic [15:0] div;
  logic [2:0] int_en;
  logic [2:0] int_st;
  logic [2:0] int_set;
  logic [2:0] int_clr;
  logic [1:0] flags;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic rx_level;
  logic rx_ready_flag;
  logic [7:0] last_rx;
  logic [8:0] fifo [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic push;
  logic pop;
  usc_state_t rx_st;
  usc_state_t tx_st;
  logic [15:0] rx_tmr;
  logic [15:0] tx_tmr;
  logic [2:0] rx_idx;
  logic [2:0] tx_idx;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic rx_bad;
  logic tx_go;
  logic tx_stop_go;
  logic ctrl_wr;

  function automatic logic par_bit(input logic [7:0] d, input usc_parity_t t);
    case (t)
      USC_PAR_ODD: par_bit = ~^d;
      USC_PAR_EVEN: par_bit = ^d;
      USC_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  usc_sync u_rx_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(rx_pin),
    .level(rx_level)
  );

  // write path: address and data taken in either order
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign ctrl_wr = wr_go && aw_q == `USC_OFS_CTRL && ws_q[0];

  always_comb
  begin
    next_aw_hold = (aw_hold || (s_axi_awvalid && s_axi_awready)) && !wr_go;
    next_w_hold = (w_hold || (s_axi_wvalid && s_axi_wready)) && !wr_go;
    next_bvalid = wr_go || (s_axi_bvalid && !s_axi_bready);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USC_RESP_OKAY;
      aw_q <= 8'h00;
      w_q <= 8'h00;
      ws_q <= 2'h0;
      w16_q <= 16'h0000;
    end
    else
    begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_awready <= !next_aw_hold && !next_bvalid;
      s_axi_wready <= !next_w_hold && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= s_axi_wdata[7:0];
        w16_q <= s_axi_wdata[15:0];
        ws_q <= s_axi_wstrb[1:0];
      end
      if (wr_go)
        s_axi_bresp <= (aw_q > `USC_OFS_INT_EN || aw_q[1:0] != 2'h0) ?
          `USC_RESP_SLVERR : `USC_RESP_OKAY;
    end
  end

  // software control fields
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ren <= 1'b0;
      etx <= 1'b0;
      pe <= 1'b0;
      extra_bit_enable <= 1'b0;
      spt <= USC_PAR_ODD;
      div <= `USC_DIV_RST;
      int_en <= 3'h0;
    end
    else if (wr_go && ws_q[0])
    begin
      case (aw_q)
        `USC_OFS_CTRL:
        begin
          ren <= w_q[`USC_CTRL_REN];
          etx <= w_q[`USC_CTRL_ETX];
        end
        `USC_OFS_MODE:
        begin
          pe <= w_q[`USC_MODE_PE];
          extra_bit_enable <= w_q[`USC_MODE_XBE];
          spt <= usc_parity_t'(w_q[`USC_MODE_SPT_HI:`USC_MODE_SPT_LO]);
        end
        `USC_OFS_DIV: div <= ws_q[1] ? w16_q : {div[15:8], w_q};
        `USC_OFS_INT_EN: int_en <= w_q[2:0];
        default: ;
      endcase
    end
  end

  // flags[0] parity error, flags[1] tx done; writing 0 clears, 1 keeps
  assign flag_set[0] = pe && cnt != '0 && fifo[rp][8];
  assign flag_set[1] = tx_stop_go;
  assign flag_clr[0] = ctrl_wr && !w_q[`USC_CTRL_PARITY_ERROR_FLAG];
  assign flag_clr[1] = ctrl_wr && !w_q[`USC_CTRL_TXD];
  usc_sticky #(.W(2)) u_flags (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set(flag_set),
    .clr(flag_clr),
    .q(flags)
  );

  assign int_set = {flag_set[0], tx_stop_go, push};
  assign int_clr = (wr_go && ws_q[0] && aw_q == `USC_OFS_INT_CLR) ? w_q[2:0] : 3'h0;
  usc_sticky #(.W(3)) u_int (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set(int_set),
    .clr(int_clr),
    .q(int_st)
  );

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(int_st & int_en);
  end

  // read path; a data read pops only while bytes are waiting
  assign pop = rd_go && s_axi_araddr == `USC_OFS_DATA && cnt != '0;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `USC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !(rd_go || (s_axi_rvalid && !s_axi_rready));
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `USC_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        case (s_axi_araddr)
          `USC_OFS_CTRL: s_axi_rdata[7:0] <= {1'b0, flags[0], 1'b0, ren, etx, erx,
            flags[1], rx_ready_flag};
          `USC_OFS_MODE: s_axi_rdata[7:0] <= {tx_st != USC_IDLE, spt, pe, 2'h0, extra_bit_enable, 1'b0};
          `USC_OFS_DATA: s_axi_rdata[7:0] <= (cnt != '0) ? fifo[rp][7:0] : last_rx;
          `USC_OFS_DIV: s_axi_rdata[15:0] <= div;
          `USC_OFS_INT_ST: s_axi_rdata[2:0] <= int_st;
          `USC_OFS_INT_CLR: s_axi_rdata <= 32'h0;
          `USC_OFS_INT_EN: s_axi_rdata[2:0] <= int_en;
          default: s_axi_rresp <= `USC_RESP_SLVERR;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // receive fifo; ready flag mirrors occupancy, overflow drops the byte
  always_comb
  begin
    next_cnt = cnt;
    if (push && !pop && cnt != DEPTH[AW:0])
      next_cnt = cnt + 1'b1;
    else if (pop && !push)
      next_cnt = cnt - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      rx_ready_flag <= 1'b0;
      last_rx <= 8'h00;
    end
    else
    begin
      cnt <= next_cnt;
      rx_ready_flag <= next_cnt != '0;
      if (pop)
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      if (push && (cnt != DEPTH[AW:0] || pop))
      begin
        fifo[wp] <= {rx_bad, rx_sh};
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
        last_rx <= rx_sh;
      end
    end
  end

  // receiver: samples mid-bit, pushes at the stop sample
  assign push = rx_st == USC_STOP && rx_tmr == 16'h0 && ren;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_st <= USC_IDLE;
      rx_tmr <= 16'h0;
      rx_idx <= 3'h0;
      rx_sh <= 8'h00;
      rx_bad <= 1'b0;
      erx <= 1'b0;
    end
    else
    begin
      rx_tmr <= (rx_tmr == 16'h0) ? div : rx_tmr - 1'b1;
      case (rx_st)
        USC_IDLE:
        begin
          rx_tmr <= {1'b0, div[15:1]};
          rx_bad <= 1'b0;
          if (!rx_level)
            rx_st <= USC_START;
        end
        USC_START:
          if (rx_tmr == 16'h0)
          begin
            rx_idx <= 3'h0;
            rx_st <= rx_level ? USC_IDLE : USC_DATA;
          end
        USC_DATA:
          if (rx_tmr == 16'h0)
          begin
            rx_sh <= {rx_level, rx_sh[7:1]};
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx == 3'h7)
              rx_st <= (pe || extra_bit_enable) ? USC_EXTRA : USC_STOP;
          end
        USC_EXTRA:
          if (rx_tmr == 16'h0)
          begin
            if (pe)
              rx_bad <= rx_level != par_bit(rx_sh, spt);
            if (extra_bit_enable)
              erx <= rx_level;
            rx_st <= USC_STOP;
          end
        USC_STOP:
          if (rx_tmr == 16'h0)
            rx_st <= USC_IDLE;
        default: rx_st <= USC_IDLE;
      endcase
    end
  end

  // transmitter: a data write while busy is ignored
  assign tx_go = wr_go && ws_q[0] && aw_q == `USC_OFS_DATA && tx_st == USC_IDLE;
  assign tx_stop_go = tx_tmr == 16'h0 && ((tx_st == USC_EXTRA) ||
    (tx_st == USC_DATA && tx_idx == 3'h7 && !(pe || extra_bit_enable)));

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_st <= USC_IDLE;
      tx_tmr <= 16'h0;
      tx_idx <= 3'h0;
      tx_sh <= 8'h00;
      tx_pin <= 1'b1;
    end
    else
    begin
      tx_tmr <= (tx_tmr == 16'h0) ? div : tx_tmr - 1'b1;
      case (tx_st)
        USC_IDLE:
          if (tx_go)
          begin
            tx_sh <= w_q;
            tx_pin <= 1'b0;
            tx_tmr <= div;
            tx_st <= USC_START;
          end
        USC_START:
          if (tx_tmr == 16'h0)
          begin
            tx_pin <= tx_sh[0];
            tx_idx <= 3'h0;
            tx_st <= USC_DATA;
          end
        USC_DATA:
          if (tx_tmr == 16'h0)
          begin
            tx_idx <= tx_idx + 1'b1;
            if (tx_idx == 3'h7)
            begin
              tx_st <= (pe || extra_bit_enable) ? USC_EXTRA : USC_STOP;
              tx_pin <= !(pe || extra_bit_enable) ? 1'b1 : pe ? par_bit(tx_sh, spt) : etx;
            end
            else
              tx_pin <= tx_sh[tx_idx + 3'h1];
          end
        USC_EXTRA:
          if (tx_tmr == 16'h0)
          begin
            tx_pin <= 1'b1;
            tx_st <= USC_STOP;
          end
        USC_STOP:
          if (tx_tmr == 16'h0)
            tx_st <= USC_IDLE;
        default: tx_st <= USC_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_PARITY_ERROR_FLAG_CLEAR: assert property ($fell(flags[0]) |-> $past(flag_clr[0]))
    else $error("parity flag fell without a clearing write");
  AST_PARITY_ERROR_FLAG_SET: assert property (flag_set[0] |=> flags[0])
    else $error("parity mismatch did not set flag");
  AST_REN_GATE: assert property (!ren && rx_st == USC_STOP && rx_tmr == 16'h0
    |=> wp == $past(wp) && last_rx == $past(last_rx))
    else $error("byte loaded while receive disabled");
  AST_EXTRA_TX: assert property (tx_st == USC_DATA && tx_idx == 3'h7 && tx_tmr == 16'h0
    && extra_bit_enable && !pe |=> tx_st == USC_EXTRA && tx_pin == $past(etx))
    else $error("extra bit level wrong");
  AST_EXTRA_RX: assert property (rx_st == USC_EXTRA && rx_tmr == 16'h0 && extra_bit_enable
    |=> erx == $past(rx_level))
    else $error("extra receive bit not captured");
  AST_NO_EXTRA: assert property (tx_st == USC_DATA && tx_idx == 3'h7 && tx_tmr == 16'h0
    && !pe && !extra_bit_enable |=> tx_st == USC_STOP && tx_pin)
    else $error("extra bit sent while disabled");
  AST_TXD_STOP: assert property ($rose(tx_st == USC_STOP) |-> flags[1])
    else $error("tx done not set at stop bit");
  AST_IRQ: assert property (int_st[1] && int_en[1] |=> irq)
    else $error("enabled tx done gave no interrupt");
  AST_TXD_HOLD: assert property (flags[1] && !flag_clr[1] |=> flags[1])
    else $error("tx done cleared by hardware");
  AST_RXR_SET: assert property (push && cnt != DEPTH[AW:0] |=> rx_ready_flag)
    else $error("rx ready not set at stop sample");
  AST_RXR_OCC: assert property (rx_ready_flag == (cnt != '0))
    else $error("rx ready does not follow occupancy");
  AST_EMPTY_RD: assert property (rd_go && s_axi_araddr == `USC_OFS_DATA && cnt == '0
    && !push |=> s_axi_rdata[7:0] == last_rx && rp == $past(rp))
    else $error("empty read changed fifo or data");

  COV_TX_FRAME: cover property ($rose(tx_st == USC_STOP));
  COV_RX_BYTE: cover property (push);
  COV_PARITY_ERROR_FLAG: cover property ($rose(flags[0]));
  COV_EMPTY_READ: cover property (rd_go && s_axi_araddr == `USC_OFS_DATA && cnt == '0);
endmodule : usc_top

//--- core/usc_map.svh
// register offsets, field positions and reset values of the serial control block
`ifndef USC_MAP_SVH
`define USC_MAP_SVH
`define USC_OFS_CTRL 8'h00
`define USC_OFS_MODE 8'h04
`define USC_OFS_DATA 8'h08
`define USC_OFS_DIV 8'h0c
`define USC_OFS_INT_ST 8'h10
`define USC_OFS_INT_CLR 8'h14
`define USC_OFS_INT_EN 8'h18
`define USC_CTRL_PARITY_ERROR_FLAG 6
`define USC_CTRL_REN 4
`define USC_CTRL_ETX 3
`define USC_CTRL_ERX 2
`define USC_CTRL_TXD 1
`define USC_CTRL_RXR 0
`define USC_MODE_BUSY 7
`define USC_MODE_SPT_HI 6
`define USC_MODE_SPT_LO 5
`define USC_MODE_PE 4
`define USC_MODE_XBE 1
`define USC_INT_RX 0
`define USC_INT_TX 1
`define USC_INT_PARITY_ERROR_FLAG 2
`define USC_DIV_RST 16'h01b2
`define USC_RESP_OKAY 2'h0
`define USC_RESP_SLVERR 2'h2
`endif

//--- core/usc_pkg.sv
// types shared by the serial control block
package usc_pkg;
  typedef enum logic [4:0] {
    USC_IDLE = 5'h01,
    USC_START = 5'h02,
    USC_DATA = 5'h04,
    USC_EXTRA = 5'h08,
    USC_STOP = 5'h10
  } usc_state_t;
  typedef enum logic [1:0] {
    USC_PAR_ODD = 2'h0,
    USC_PAR_EVEN = 2'h1,
    USC_PAR_MARK = 2'h2,
    USC_PAR_SPACE = 2'h3
  } usc_parity_t;
endpackage : usc_pkg

//--- core/usc_sync.sv
// three-stage input synchroniser with agreement filter
module usc_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule : usc_sync

//--- core/usc_sticky.sv
// sticky flags, set wins over clear
module usc_sticky #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= (q & ~clr) | set;
  end
endmodule : usc_sticky

//--- tb/usc_remote.sv
// remote serial station: drives rx_pin frames, decodes tx_pin frames
module usc_remote #(
  parameter int BC = 8
) (
  input wire logic ref_clk,
  input wire logic tx_pin,
  input wire logic xen,
  output logic rx_pin,
  output logic [9:0] got,
  output int cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_pin = 1'b1;
  initial cnt = 0;
  initial got = 10'h000;
  // start, data lsb first, optional extra slot, stop, then idle high
  task automatic send(input logic [8:0] f, input logic x);
    logic [11:0] fr;
    fr = x ? {2'b11, f, 1'b0} : {3'b111, f[7:0], 1'b0};
    for (int i = 0; i < 12; i++)
      repeat (BC) @(posedge ref_clk) rx_pin <= fr[i];
  endtask : send
  // mid-bit sampling; got[9] holds the stop level
  initial forever
  begin
    @(posedge ref_clk);
    if (tx_pin === 1'b0)
    begin
      got = 10'h000;
      repeat (BC / 2) @(posedge ref_clk);
      for (int i = 0; i < 8 + int'(xen); i++)
      begin
        repeat (BC) @(posedge ref_clk);
        got[i] = tx_pin;
      end
      repeat (BC) @(posedge ref_clk);
      got[9] = tx_pin;
      cnt++;
    end
  end
endmodule : usc_remote

//--- tb/usc_top_tb.sv
// self-checking bench for the serial control block
`include "usc_map.svh"
module usc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIVV = 7;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic xen = 1'b0;
  logic awr, wrd, bv, arr, rv, rxp, txp, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rd, v;
  logic [9:0] got;
  int cnt;
  int err_total = 0;
  int comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  usc_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .rx_pin(rxp), .tx_pin(txp),
    .irq(irq));
  usc_remote #(.BC(DIVV + 1)) u_rem (.ref_clk(ref_clk), .tx_pin(txp), .xen(xen), .rx_pin(rxp),
    .got(got), .cnt(cnt));
  task report_and_stop;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task tmo;
    chk(32'h0, 32'h1);
    report_and_stop();
  endtask : tmo
  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv)
      begin
        done = 1'b1;
        br <= 1'b0;
        chk(bresp, er);
      end
    end
    if (!done) tmo();
  endtask : wr
  task rdr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    d = 32'h0;
    @(posedge ref_clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge ref_clk);
      if (arr) arv <= 1'b0;
      if (rv)
      begin
        done = 1'b1;
        rr <= 1'b0;
        d = rd;
        chk(rresp, er);
      end
    end
    if (!done) tmo();
  endtask : rdr
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdr(a, v, `USC_RESP_OKAY);
    chk(v & m, e);
  endtask : rchk
  task ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, `USC_RESP_OKAY);
  endtask : ok
  task t_reset;
    rchk(`USC_OFS_CTRL, 32'hfb, 32'h0);
    rdr(8'h1c, v, `USC_RESP_SLVERR);
    chk(v, 32'h0);
    chk(irq, 1'b0);
    ok(`USC_OFS_DIV, DIVV);
  endtask : t_reset
  task t_rx;
    ok(`USC_OFS_INT_EN, 32'h7);
    ok(`USC_OFS_CTRL, 32'h10);
    u_rem.send(9'h05a, 1'b0);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h1);
    chk(irq, 1'b1);
    rchk(`USC_OFS_DATA, 32'hff, 32'h5a);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h0);
    rchk(`USC_OFS_DATA, 32'hff, 32'h5a);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h0);
    ok(`USC_OFS_INT_CLR, 32'h1);
    rchk(`USC_OFS_INT_ST, 32'h1, 32'h0);
    chk(irq, 1'b0);
    u_rem.send(9'h011, 1'b0);
    u_rem.send(9'h022, 1'b0);
    rchk(`USC_OFS_DATA, 32'hff, 32'h11);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h1);
    rchk(`USC_OFS_DATA, 32'hff, 32'h22);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h0);
    // status still set, so a masked enable must keep irq low
    ok(`USC_OFS_INT_EN, 32'h6);
    rchk(`USC_OFS_INT_ST, 32'h1, 32'h1);
    chk(irq, 1'b0);
    ok(`USC_OFS_INT_CLR, 32'h7);
  endtask : t_rx
  task t_ren;
    // a byte held before disabling must stay readable
    u_rem.send(9'h044, 1'b0);
    ok(`USC_OFS_CTRL, 32'h00);
    u_rem.send(9'h033, 1'b0);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h1);
    rchk(`USC_OFS_DATA, 32'hff, 32'h44);
    rchk(`USC_OFS_CTRL, 32'h1, 32'h0);
    rchk(`USC_OFS_DATA, 32'hff, 32'h44);
  endtask : t_ren
  task tx_one(input logic [7:0] d, input logic x, input logic e);
    int c0;
    c0 = cnt;
    ok(`USC_OFS_CTRL, {24'h0, 4'h1, x, 3'h0});
    ok(`USC_OFS_DATA, {24'h0, d});
    for (int n = 0; n < 400 && cnt == c0; n++)
      @(posedge ref_clk);
    if (cnt == c0) tmo();
    chk(got, {1'b1, e, d});
    rchk(`USC_OFS_CTRL, 32'h2, 32'h2);
    chk(irq, 1'b1);
    ok(`USC_OFS_CTRL, {24'h0, 4'h1, x, 3'h0});
    rchk(`USC_OFS_CTRL, 32'h2, 32'h0);
    ok(`USC_OFS_INT_CLR, 32'h7);
  endtask : tx_one
  task t_extra;
    ok(`USC_OFS_MODE, 32'h02);
    xen <= 1'b1;
    ok(`USC_OFS_CTRL, 32'h10);
    u_rem.send(9'h13c, 1'b1);
    rchk(`USC_OFS_CTRL, 32'h4, 32'h4);
    rchk(`USC_OFS_DATA, 32'hff, 32'h3c);
    u_rem.send(9'h0c3, 1'b1);
    rchk(`USC_OFS_CTRL, 32'h4, 32'h0);
    rchk(`USC_OFS_DATA, 32'hff, 32'hc3);
    tx_one(8'ha5, 1'b1, 1'b1);
    tx_one(8'h5a, 1'b0, 1'b0);
  endtask : t_extra
  // even parity: 0x01 needs a parity slot of 1
  task t_par;
    ok(`USC_OFS_MODE, 32'h30);
    ok(`USC_OFS_CTRL, 32'h10);
    u_rem.send(9'h001, 1'b1);
    rchk(`USC_OFS_CTRL, 32'h40, 32'h40);
    rchk(`USC_OFS_DATA, 32'hff, 32'h01);
    ok(`USC_OFS_CTRL, 32'h10);
    rchk(`USC_OFS_CTRL, 32'h40, 32'h0);
    u_rem.send(9'h101, 1'b1);
    rchk(`USC_OFS_CTRL, 32'h40, 32'h0);
    rchk(`USC_OFS_DATA, 32'hff, 32'h01);
    // odd parity: 0x01 with a parity slot of 1 is bad
    ok(`USC_OFS_MODE, 32'h10);
    rchk(`USC_OFS_MODE, 32'h7f, 32'h10);
    ok(`USC_OFS_INT_CLR, 32'h7);
    rchk(`USC_OFS_INT_ST, 32'h4, 32'h0);
    u_rem.send(9'h101, 1'b1);
    rchk(`USC_OFS_CTRL, 32'h40, 32'h40);
    rchk(`USC_OFS_INT_ST, 32'h4, 32'h4);
    rchk(`USC_OFS_DATA, 32'hff, 32'h01);
    ok(`USC_OFS_CTRL, 32'h10);
    rchk(`USC_OFS_CTRL, 32'h40, 32'h0);
    ok(`USC_OFS_INT_CLR, 32'h7);
    // mark parity wins over the extra transmit bit
    ok(`USC_OFS_MODE, 32'h50);
    tx_one(8'h00, 1'b0, 1'b1);
  endtask : t_par
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_rx();
    t_ren();
    t_extra();
    t_par();
    report_and_stop();
  end
endmodule : usc_top_tb
